// ### dsp_slice_regs.vh
`ifndef DSP_SLICE_REGS_VH
`define DSP_SLICE_REGS_VH

// register byte offsets on the apb bus
`define CTRL_ADDR 8'h00
`define PRELOAD_LO_ADDR 8'h04
`define PRELOAD_HI_ADDR 8'h08
`define COEF_ADDR_ADDR 8'h0c
`define COEF_DATA_ADDR 8'h10
`define RESULT_LO_ADDR 8'h14
`define RESULT_HI_ADDR 8'h18

// reset values
`define CTRL_RST 32'h0000_0000
`define PRELOAD_RST 64'h0000_0000_0000_0000
`define COEF_ADDR_RST 4'h0

// control register field positions
`define F_FP 0
`define F_M27 1
`define F_PLUS36 2
`define F_IN_BYP 3
`define F_PIPE_EN 4
`define F_FP_LAY 5
`define F_PRE_EN 7
`define F_PRE_SUB 8
`define F_COEF_EN 9
`define F_SYST 10
`define F_DBL 11
`define F_TAP 12
`define F_DELAY 13
`define F_SIGNED 14
`define F_CHAIN 15
`define F_IN_CLK 16
`define F_IN_GATE 18
`define F_PIPE_CLK 20
`define F_PIPE_GATE 22
`define F_OUT_CLK 24
`define F_OUT_GATE 26
`define CTRL_USED_MASK 32'h0fff_ffff

// single precision constants
`define FP_BIAS 10'h07f
`define FP_EXP_MAX 8'hff

`endif

// ### coef_store.v
`timescale 1ns/1ps
module coef_store #(
  parameter WIDTH = 27,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire rd_en_i,
  input wire [AW-1:0] rd_addr_a_i,
  input wire [AW-1:0] rd_addr_b_i,
  output reg [WIDTH-1:0] rd_data_a_o,
  output reg [WIDTH-1:0] rd_data_b_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
      rd_data_a_o <= {WIDTH{1'b0}};
      rd_data_b_o <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wr_en_i)
        mem[wr_addr_i] <= wr_data_i;
      if (rd_en_i)
      begin
        rd_data_a_o <= mem[rd_addr_a_i];
        rd_data_b_o <= mem[rd_addr_b_i];
      end
    end
  end
endmodule

// ### dsp_slice.v
// How it works
// RULE1: all registers update on rising edge and start at zero.
// RULE2: each operand uses its input register or bypasses it.
// RULE3: input bank picks one of three ticks and gates, clear line zero.
// RULE4: fixed mode registers all controls; float registers only accumulate.
// RULE5: 18x19 mode offers top and bottom delay registers on cascade.
// RULE6: no delay registers in wide-input or 27x27 configurations.
// RULE7: tap delay feeds upper legs from routing or cascade chain.
// RULE8: optional pipeline stage, shared ticks and gates, clear line one.
// RULE9: float mode uses zero, one or two pipeline layers.
// RULE10: two 19-bit pre-adders or one combined 27-bit pre-adder.
// RULE11: pre-adders take 18-bit or 26-bit signed or unsigned operands.
// RULE12: software sets one add/subtract choice for both pre-adders.
// RULE13: multiplicand comes from input or one of eight constants.
// RULE14: one 27x27, two 18x19 or one float multiply.
// RULE15: final adder is 55-bit, 38-bit or single precision float.
// RULE16: dynamic subtract select works in fixed mode only.
// RULE17: systolic registers bypassed unless fixed systolic mode outside 27x27.
// RULE18: accumulator and chainout adder in both fixed and float.
// RULE19: controls pick zero, preload, previous sum, or negated result.
// RULE20: double accumulation adds one cycle to feedback.
// RULE21: coefficient picks are three bits wide.
`timescale 1ns/1ps
`include "dsp_slice_regs.vh"
module dsp_slice (
  input wire clock_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [2:0] clock_tick_i,
  input wire [2:0] register_gate_i,
  input wire [1:0] async_clear_i,
  input wire [26:0] upper_leg_operand_first_i,
  input wire [25:0] first_preadd_i,
  input wire [26:0] first_multiplicand_i,
  input wire [18:0] upper_leg_operand_second_i,
  input wire [17:0] second_preadd_i,
  input wire [17:0] second_multiplicand_i,
  input wire [26:0] scan_in_i,
  input wire [63:0] chainin_i,
  input wire sub_i,
  input wire negate_i,
  input wire accumulate_i,
  input wire preload_select_i,
  input wire [2:0] top_coef_pick_i,
  input wire [2:0] bottom_coef_pick_i,
  output reg [26:0] scan_out_o,
  output reg [63:0] result_o
);
  reg [31:0] ctrl_reg;
  reg [63:0] preload_reg;
  reg [3:0] caddr_reg;
  reg [31:0] rdata_next;
  reg hit_next;

  function sel3(input [2:0] v, input [1:0] s);
    sel3 = (s > 2'd2) ? v[2] : v[s];
  endfunction

  function [31:0] fp_mul(input [31:0] a, input [31:0] b);
    reg [47:0] m;
    reg [9:0] e;
    reg s;
    begin
      s = a[31] ^ b[31];
      m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - `FP_BIAS + {9'h000, m[47]};
      if (m[47])
        m = m >> 1;
      if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9])
        fp_mul = {s, 31'h0000_0000};
      else if (e[8] || e[7:0] == `FP_EXP_MAX)
        fp_mul = {s, `FP_EXP_MAX, 23'h00_0000};
      else
        fp_mul = {s, e[7:0], m[45:23]};
    end
  endfunction

  function [31:0] fp_add(input [31:0] a, input [31:0] b);
    reg [31:0] x;
    reg [31:0] y;
    reg [7:0] d;
    reg [25:0] mx;
    reg [25:0] my;
    reg [25:0] s;
    reg [8:0] e;
    integer i;
    begin
      x = (a[30:0] < b[30:0]) ? b : a;
      y = (a[30:0] < b[30:0]) ? a : b;
      d = x[30:23] - y[30:23];
      mx = (x[30:23] == 8'h00) ? 26'h000_0000 : {2'b01, x[22:0], 1'b0};
      my = (y[30:23] == 8'h00) ? 26'h000_0000 : ({2'b01, y[22:0], 1'b0} >> d);
      s = (x[31] ^ y[31]) ? mx - my : mx + my;
      e = {1'b0, x[30:23]};
      if (s[25])
      begin
        s = s >> 1;
        e = e + 9'h001;
      end
      else
        for (i = 0; i < 24; i = i + 1)
          if (!s[24] && s != 26'h000_0000 && e != 9'h000)
          begin
            s = s << 1;
            e = e - 9'h001;
          end
      if (s == 26'h000_0000 || e == 9'h000)
        fp_add = 32'h0000_0000;
      else if (e >= {1'b0, `FP_EXP_MAX})
        fp_add = {x[31], `FP_EXP_MAX, 23'h00_0000};
      else
        fp_add = {x[31], e[7:0], s[23:1]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode and tick selection
  wire fp = ctrl_reg[`F_FP];
  wire m27 = ctrl_reg[`F_M27] & ~fp;
  wire plus36 = ctrl_reg[`F_PLUS36] & ~fp & ~m27;
  wire sgn = ctrl_reg[`F_SIGNED];
  wire chain_en = ctrl_reg[`F_CHAIN];
  // RULE2: input bypass select
  wire in_byp = ctrl_reg[`F_IN_BYP];
  // RULE6: delay registers limited
  wire delay_ok = ctrl_reg[`F_DELAY] & ~fp & ~m27 & ~plus36;
  // RULE17: systolic bypass unless fixed and not 27x27
  wire sys_en = ctrl_reg[`F_SYST] & ~fp & ~m27;
  wire dbl_ok = ctrl_reg[`F_DBL] & ~fp;
  // RULE3: input bank tick and gate
  wire in_tick = sel3(clock_tick_i, ctrl_reg[`F_IN_CLK+1:`F_IN_CLK]) &
                 sel3(register_gate_i, ctrl_reg[`F_IN_GATE+1:`F_IN_GATE]);
  // RULE8: pipeline tick and gate
  wire pipe_tick = sel3(clock_tick_i, ctrl_reg[`F_PIPE_CLK+1:`F_PIPE_CLK]) &
                   sel3(register_gate_i, ctrl_reg[`F_PIPE_GATE+1:`F_PIPE_GATE]);
  wire out_tick = sel3(clock_tick_i, ctrl_reg[`F_OUT_CLK+1:`F_OUT_CLK]) &
                  sel3(register_gate_i, ctrl_reg[`F_OUT_GATE+1:`F_OUT_GATE]);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire setup = psel_i & ~penable_i;
  wire wr_acc = psel_i & penable_i & pready_o & pwrite_i;

  always @*
  begin
    hit_next = (paddr_i[1:0] == 2'b00);
    case (paddr_i)
      `CTRL_ADDR: rdata_next = ctrl_reg;
      `PRELOAD_LO_ADDR: rdata_next = preload_reg[31:0];
      `PRELOAD_HI_ADDR: rdata_next = preload_reg[63:32];
      `COEF_ADDR_ADDR: rdata_next = {28'h000_0000, caddr_reg};
      `COEF_DATA_ADDR: rdata_next = 32'h0000_0000;
      `RESULT_LO_ADDR: rdata_next = result_o[31:0];
      `RESULT_HI_ADDR: rdata_next = result_o[63:32];
      default:
      begin
        rdata_next = 32'h0000_0000;
        hit_next = 1'b0;
      end
    endcase
  end

  // RULE1: configuration cleared at reset
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= `CTRL_RST;
      preload_reg <= `PRELOAD_RST;
      caddr_reg <= `COEF_ADDR_RST;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= setup;
      pslverr_o <= setup & ~hit_next;
      prdata_o <= (setup & ~pwrite_i) ? rdata_next : 32'h0000_0000;
      if (wr_acc)
        case (paddr_i)
          `CTRL_ADDR: ctrl_reg <= pwdata_i & `CTRL_USED_MASK;
          `PRELOAD_LO_ADDR: preload_reg[31:0] <= pwdata_i;
          `PRELOAD_HI_ADDR: preload_reg[63:32] <= pwdata_i;
          `COEF_ADDR_ADDR: caddr_reg <= pwdata_i[3:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input register bank with tap delay and delay registers
  reg [26:0] ay_r;
  reg [25:0] az_r;
  reg [26:0] ax_r;
  reg [18:0] by_r;
  reg [17:0] bz_r;
  reg [17:0] bx_r;
  reg [26:0] top_dly_r;
  reg [18:0] bot_dly_r;
  reg [3:0] ctl_r;

  // RULE7: upper legs from cascade
  wire [26:0] ay_src = ctrl_reg[`F_TAP] ? scan_in_i : upper_leg_operand_first_i;
  wire [18:0] by_src = (ctrl_reg[`F_TAP] && !m27) ?
                       (delay_ok ? top_dly_r[18:0] : ay_r[18:0]) :
                       upper_leg_operand_second_i;
  wire [3:0] ctl_raw = {sub_i, negate_i, accumulate_i, preload_select_i};

  // RULE3: bank cleared by clear line zero
  always @(posedge clock_i or posedge async_clear_i[0])
  begin
    if (async_clear_i[0])
    begin
      ay_r <= 27'h000_0000;
      az_r <= 26'h000_0000;
      ax_r <= 27'h000_0000;
      by_r <= 19'h0_0000;
      bz_r <= 18'h0_0000;
      bx_r <= 18'h0_0000;
      top_dly_r <= 27'h000_0000;
      bot_dly_r <= 19'h0_0000;
      ctl_r <= 4'h0;
      scan_out_o <= 27'h000_0000;
    end
    else if (rst_i)
    begin
      ay_r <= 27'h000_0000;
      az_r <= 26'h000_0000;
      ax_r <= 27'h000_0000;
      by_r <= 19'h0_0000;
      bz_r <= 18'h0_0000;
      bx_r <= 18'h0_0000;
      top_dly_r <= 27'h000_0000;
      bot_dly_r <= 19'h0_0000;
      ctl_r <= 4'h0;
      scan_out_o <= 27'h000_0000;
    end
    else if (in_tick)
    begin
      ay_r <= ay_src;
      az_r <= first_preadd_i;
      ax_r <= first_multiplicand_i;
      by_r <= by_src;
      bz_r <= second_preadd_i;
      bx_r <= second_multiplicand_i;
      // RULE5: delay registers equalise cascade
      top_dly_r <= ay_r;
      bot_dly_r <= by_r;
      ctl_r <= ctl_raw;
      scan_out_o <= m27 ? ay_r :
                    {8'h00, (delay_ok ? bot_dly_r : by_r)};
    end
  end

  wire [26:0] ay_s = in_byp ? ay_src : ay_r;
  wire [25:0] az_s = in_byp ? first_preadd_i : az_r;
  wire [26:0] ax_s = in_byp ? first_multiplicand_i : ax_r;
  wire [18:0] by_s = in_byp ? by_src : by_r;
  wire [17:0] bz_s = in_byp ? second_preadd_i : bz_r;
  wire [17:0] bx_s = in_byp ? second_multiplicand_i : bx_r;
  // RULE4: float registers accumulate only
  wire [3:0] ctl_s = in_byp ? ctl_raw :
                     fp ? {ctl_raw[3:2], ctl_r[1], ctl_raw[0]} : ctl_r;

  ////////////////////////////////////////////////////////////////////////////
  // pre-adders and coefficient store
  wire pre_en = ctrl_reg[`F_PRE_EN] & ~fp;
  // RULE12: one shared add/subtract bit
  wire pre_sub = ctrl_reg[`F_PRE_SUB];
  // RULE11: operand sign extension
  wire [18:0] ya_op = {sgn & ay_s[17], ay_s[17:0]};
  wire [18:0] za_op = {sgn & az_s[17], az_s[17:0]};
  wire [18:0] yb_op = {sgn & by_s[17], by_s[17:0]};
  wire [18:0] zb_op = {sgn & bz_s[17], bz_s[17:0]};
  wire [26:0] y27_op = {sgn & ay_s[25], ay_s[25:0]};
  wire [26:0] z27_op = {sgn & az_s[25], az_s[25:0]};
  // RULE10: split or combined pre-adder
  wire [18:0] ya_pre = pre_sub ? ya_op - za_op : ya_op + za_op;
  wire [18:0] yb_pre = pre_sub ? yb_op - zb_op : yb_op + zb_op;
  wire [26:0] y27_pre = pre_sub ? y27_op - z27_op : y27_op + z27_op;
  wire [26:0] ya_v = !pre_en ? ay_s : m27 ? y27_pre : {8'h00, ya_pre};
  wire [18:0] yb_v = pre_en ? yb_pre : by_s;

  wire [26:0] coef_top;
  wire [26:0] coef_bot;
  wire coef_wr = wr_acc && (paddr_i == `COEF_DATA_ADDR);

  // RULE21: three bit coefficient picks
  coef_store #(
    .WIDTH(27),
    .DEPTH(16),
    .AW(4)
  ) u_coef (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_en_i(coef_wr),
    .wr_addr_i(caddr_reg),
    .wr_data_i(pwdata_i[26:0]),
    .rd_en_i(in_tick | in_byp),
    .rd_addr_a_i({1'b0, top_coef_pick_i}),
    .rd_addr_b_i({1'b1, bottom_coef_pick_i}),
    .rd_data_a_o(coef_top),
    .rd_data_b_o(coef_bot)
  );

  // RULE13: coefficient or dynamic multiplicand
  wire coef_en = ctrl_reg[`F_COEF_EN] & ~fp;
  wire [26:0] xa_v = coef_en ? coef_top : ax_s;
  wire [17:0] xb_v = coef_en ? coef_bot[17:0] : bx_s;

  ////////////////////////////////////////////////////////////////////////////
  // pipeline layers
  wire [94:0] st0 = {ya_v, yb_v, xa_v, xb_v, ctl_s};
  reg [94:0] p1_r;
  reg [94:0] p2_r;
  // RULE9: zero, one or two layers
  wire [1:0] layers = fp ? ctrl_reg[`F_FP_LAY+1:`F_FP_LAY] :
                      {1'b0, ctrl_reg[`F_PIPE_EN]};
  wire [94:0] st = (layers == 2'd0) ? st0 : (layers == 2'd1) ? p1_r : p2_r;

  // RULE8: pipeline cleared by clear line one
  always @(posedge clock_i or posedge async_clear_i[1])
  begin
    if (async_clear_i[1])
    begin
      p1_r <= 95'h0;
      p2_r <= 95'h0;
    end
    else if (rst_i)
    begin
      p1_r <= 95'h0;
      p2_r <= 95'h0;
    end
    else if (pipe_tick)
    begin
      p1_r <= st0;
      p2_r <= p1_r;
    end
  end

  wire [26:0] ya = st[94:68];
  wire [18:0] yb = st[67:49];
  wire [26:0] xa = st[48:22];
  wire [17:0] xb = st[21:4];
  wire sub = st[3] & ~fp;
  wire neg = st[2];
  wire acc = st[1];
  wire pre = st[0];

  ////////////////////////////////////////////////////////////////////////////
  // multipliers, adder, accumulator and chainout
  // RULE14: multiplier configurations
  wire signed [55:0] p27 = $signed({sgn & ya[26], ya}) *
                           $signed({sgn & xa[26], xa});
  wire signed [37:0] pa = $signed(ya[18:0]) * $signed({sgn & xa[17], xa[17:0]});
  wire signed [37:0] pb = $signed(yb) * $signed({sgn & xb[17], xb});
  wire [31:0] fp_prod = fp_mul({yb[4:0], xa}, {xb[4:0], ya});

  reg [37:0] sys_pa_r;
  reg [63:0] sys_chain_r;
  reg [63:0] dbl_r;
  wire [37:0] pa_use = sys_en ? sys_pa_r : pa;
  wire [63:0] chain_use = sys_en ? sys_chain_r : chainin_i;
  wire [63:0] pa64 = {{26{pa_use[37]}}, pa_use};
  wire [63:0] pb64 = {{26{pb[37]}}, pb};
  wire [35:0] wide = {yb[17:0], xb};
  wire [63:0] wide64 = {{28{sgn & wide[35]}}, wide};
  wire [63:0] sec = plus36 ? wide64 : pb64;
  // RULE15: 55-bit or 38-bit adder
  // RULE16: dynamic subtract fixed only
  wire [63:0] sum_fix = m27 ? {{8{p27[55]}}, p27} :
                        sub ? pa64 - sec : pa64 + sec;
  // RULE19: accumulator control decode
  wire [63:0] cur_fix = neg ? 64'h0 - sum_fix : sum_fix;
  // RULE20: double accumulation feedback
  wire [63:0] prev = dbl_ok ? dbl_r : result_o;
  wire [63:0] fb = acc ? prev : pre ? preload_reg : 64'h0;
  wire [63:0] chain_term = chain_en ? chain_use : 64'h0;
  // RULE18: accumulator and chainout adder
  wire [63:0] total_fix = cur_fix + fb + chain_term;
  wire [31:0] cur_fp = neg ? {~fp_prod[31], fp_prod[30:0]} : fp_prod;
  wire [31:0] fb_fp = acc ? prev[31:0] : chain_term[31:0];
  wire [31:0] total_fp = fp_add(cur_fp, fb_fp);
  wire [63:0] out_next = fp ? {32'h0000_0000, total_fp} : total_fix;

  ////////////////////////////////////////////////////////////////////////////
  // output bank, double accumulation and systolic registers
  always @(posedge clock_i or posedge async_clear_i[1])
  begin
    if (async_clear_i[1])
    begin
      result_o <= 64'h0;
      dbl_r <= 64'h0;
      sys_pa_r <= 38'h0;
      sys_chain_r <= 64'h0;
    end
    else if (rst_i)
    begin
      result_o <= 64'h0;
      dbl_r <= 64'h0;
      sys_pa_r <= 38'h0;
      sys_chain_r <= 64'h0;
    end
    else if (out_tick)
    begin
      result_o <= out_next;
      dbl_r <= result_o;
      sys_pa_r <= pa;
      sys_chain_r <= chainin_i;
    end
  end
endmodule

// ### dsp_slice_properties.sv
`timescale 1ns/1ps
module dsp_slice_properties (
  input wire clock_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire [7:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [2:0] clock_tick_i,
  input wire [1:0] async_clear_i,
  input wire [26:0] scan_out_o,
  input wire [63:0] result_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_reset_zero:
    assert property ($fell(rst_i) |-> result_o == 64'h0 && scan_out_o == 27'h0)
    else $error("outputs not zero after reset");
  a_ready_setup:
    assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_pulse:
    assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_misaligned:
    assert property (psel_i && !penable_i && paddr_i[1:0] != 2'h0
      |=> pslverr_o && pready_o && prdata_o == 32'h0)
    else $error("misaligned access not refused");
  a_err_ready:
    assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_data_idle:
    assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside access");
  a_clear_input:
    assert property (async_clear_i[0] |-> scan_out_o == 27'h0)
    else $error("input clear ignored");
  a_clear_output:
    assert property (async_clear_i[1] |-> result_o == 64'h0)
    else $error("output clear ignored");
  a_hold_no_tick:
    assert property (clock_tick_i == 3'h0 && async_clear_i == 2'h0
      |=> async_clear_i != 2'h0 || ($stable(result_o) && $stable(scan_out_o)))
    else $error("output moved without tick");
  c_err: cover property (pslverr_o);
  c_clear: cover property (async_clear_i[1] ##1 result_o == 64'h0);
  c_hold: cover property (clock_tick_i == 3'h0 [*3]);
endmodule
bind dsp_slice dsp_slice_properties chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .clock_tick_i(clock_tick_i),
  .async_clear_i(async_clear_i), .scan_out_o(scan_out_o), .result_o(result_o)
);

// ### neighbour_slice.sv
`timescale 1ns/1ps
module neighbour_slice (
  input wire clock_i,
  input wire [26:0] scan_i,
  output reg [63:0] chain_o,
  output reg [26:0] scan_o
);
  reg [63:0] chain_next = 64'h0;
  initial
  begin
    chain_o = 64'h0;
    scan_o = 27'h0;
  end
  always @(posedge clock_i)
  begin
    chain_o <= chain_next;
    scan_o <= ~scan_i;
  end
  task set_chain(input [63:0] v);
    chain_next = v;
  endtask
endmodule

// ### dsp_slice_tb.sv
`timescale 1ns/1ps
`include "dsp_slice_regs.vh"
module dsp_slice_tb;
  reg clock_i = 0;
  reg rst_i = 1;
  reg psel = 0, pen = 0, pwr = 0;
  reg [7:0] pa = 8'h0;
  reg [31:0] pwd = 32'h0;
  wire [31:0] prd;
  wire prdy, perr;
  reg [2:0] tick = 3'h7, gate = 3'h7, tp = 3'h0, bp = 3'h0;
  reg [1:0] clr = 2'h0;
  reg [26:0] y1 = 27'h0, x1 = 27'h0;
  reg [25:0] z1 = 26'h0;
  reg [18:0] y2 = 19'h0;
  reg [17:0] z2 = 18'h0, x2 = 18'h0;
  reg sub = 0, neg = 0, pre = 0, acc = 0;
  wire [63:0] chain, res;
  wire [26:0] sin, sout;
  integer num_errors = 0, total_checks = 0, cycles = 0, n0, k;
  integer lat [0:2];
  reg [31:0] q;
  reg e;
  reg [63:0] r0;
  initial forever #12.5 clock_i = ~clock_i;
  dsp_slice dut_u (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .clock_tick_i(tick),
    .register_gate_i(gate), .async_clear_i(clr),
    .upper_leg_operand_first_i(y1), .first_preadd_i(z1),
    .first_multiplicand_i(x1), .upper_leg_operand_second_i(y2),
    .second_preadd_i(z2), .second_multiplicand_i(x2), .scan_in_i(sin),
    .chainin_i(chain), .sub_i(sub), .negate_i(neg), .accumulate_i(acc),
    .preload_select_i(pre), .top_coef_pick_i(tp), .bottom_coef_pick_i(bp),
    .scan_out_o(sout), .result_o(res));
  neighbour_slice nb_u (.clock_i(clock_i), .scan_i(sout), .chain_o(chain),
    .scan_o(sin));
  task end_sim;
  begin
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clock_i);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1;
    // wait for ready; only the bench timeout ends a hung access
    do
      @(posedge clock_i);
    while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
  end
  endtask
  task op(input [26:0] a, input [25:0] b, input [26:0] c,
    input [18:0] d, input [17:0] f, input [17:0] g);
  begin
    @(posedge clock_i);
    y1 <= a;
    z1 <= b;
    x1 <= c;
    y2 <= d;
    z2 <= f;
    x2 <= g;
  end
  endtask
  task ctl(input [3:0] v);
  begin
    @(posedge clock_i);
    {sub, neg, pre, acc} <= v;
  end
  endtask
  task settle(input [63:0] exp, output integer n);
  begin
    n = 0;
    do
    begin
      @(posedge clock_i);
      n = n + 1;
    end
    while (res !== exp && n < 12);
    chk(res, exp);
  end
  endtask
  task acc_diff(input integer d, input [63:0] exp);
  begin
    repeat (4) @(posedge clock_i);
    r0 = res;
    repeat (d) @(posedge clock_i);
    chk(res - r0, exp);
  end
  endtask
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles > 4000)
    begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    chk(res, 64'h0);
    apb(0, `CTRL_ADDR, 0);
    chk(q, `CTRL_RST);
    apb(0, `PRELOAD_HI_ADDR, 0);
    chk(q, 64'h0);
    apb(1, `CTRL_ADDR, 32'hffffffff);
    apb(0, `CTRL_ADDR, 0);
    chk(q, `CTRL_USED_MASK);
    apb(0, 8'h1c, 0);
    chk({q, e}, 64'h1);
    apb(1, 8'h02, 0);
    chk(e, 64'h1);
    apb(1, `CTRL_ADDR, 32'h4008);
    op(27'h7fffffd, 0, 27'd5, 19'd7, 0, 18'h3fffe);
    settle(-64'd29, n0);
    ctl(4'h8);
    settle(-64'd1, n0);
    ctl(4'h0);
    for (k = 0; k < 3; k = k + 1)
    begin
      apb(1, `CTRL_ADDR, k == 0 ? 32'h4008 : k == 1 ? 32'h4000 : 32'h4010);
      op(27'd2, 0, 27'd3, 0, 0, 0);
      settle(64'd6, n0);
      op(27'd4, 0, 27'd3, 0, 0, 0);
      settle(64'd12, lat[k]);
    end
    chk(lat[1] - lat[0], 64'h1);
    chk(lat[2] - lat[1], 64'h1);
    apb(1, `CTRL_ADDR, 32'h4088);
    op(27'd3, 26'd4, 27'd5, 19'd1, 18'd2, 18'd6);
    settle(64'd53, n0);
    apb(1, `CTRL_ADDR, 32'h4188);
    settle(-64'd11, n0);
    apb(1, `CTRL_ADDR, 32'h400c);
    settle(64'h4_0015, n0);
    apb(1, `COEF_ADDR_ADDR, 32'h7);
    apb(1, `COEF_DATA_ADDR, 32'h9);
    apb(1, `COEF_ADDR_ADDR, 32'hd);
    apb(1, `COEF_DATA_ADDR, 32'hb);
    apb(1, `CTRL_ADDR, 32'h4208);
    tp <= 3'h7;
    bp <= 3'h5;
    op(27'd2, 0, 0, 19'd3, 0, 0);
    settle(64'd51, n0);
    apb(1, `CTRL_ADDR, 32'h400a);
    op(27'h2000000, 0, 27'h4000, 0, 0, 0);
    settle(64'h80_0000_0000, n0);
    repeat (2) @(posedge clock_i);
    chk(sout, 64'h200_0000);
    apb(1, `CTRL_ADDR, 32'h4008);
    apb(1, `PRELOAD_LO_ADDR, 32'h100);
    apb(1, `PRELOAD_HI_ADDR, 32'h1);
    op(27'd3, 0, 27'd1, 0, 0, 0);
    settle(64'd3, n0);
    ctl(4'h2);
    settle(64'h1_0000_0103, n0);
    nb_u.set_chain(64'h1000);
    apb(1, `CTRL_ADDR, 32'hc008);
    ctl(4'h4);
    settle(64'hffd, n0);
    apb(1, `CTRL_ADDR, 32'h4008);
    ctl(4'h1);
    acc_diff(1, 64'd3);
    ctl(4'h5);
    acc_diff(1, -64'd3);
    ctl(4'h0);
    apb(1, `CTRL_ADDR, 32'h4808);
    ctl(4'h1);
    acc_diff(2, 64'd3);
    ctl(4'h0);
    settle(64'd3, n0);
    tick <= 3'h0;
    op(27'd5, 0, 27'd1, 0, 0, 0);
    repeat (4) @(posedge clock_i);
    chk(res, 64'd3);
    tick <= 3'h7;
    gate <= 3'h6;
    repeat (4) @(posedge clock_i);
    chk(res, 64'd3);
    gate <= 3'h7;
    settle(64'd5, n0);
    clr <= 2'h2;
    repeat (2) @(posedge clock_i);
    chk(res, 64'h0);
    clr <= 2'h1;
    repeat (2) @(posedge clock_i);
    chk(sout, 64'h0);
    clr <= 2'h0;
    ctl(4'h8);
    for (k = 0; k < 3; k = k + 1)
    begin
      apb(1, `CTRL_ADDR, 32'h9 | (k << 5));
      op(0, 0, 0, 19'd8, 0, 18'd8);
      settle(64'h4080_0000, n0);
      op(27'h400000, 0, 0, 19'd8, 0, 18'd8);
      settle(64'h40c0_0000, lat[k]);
    end
    chk(lat[1] - lat[0], 64'h1);
    chk(lat[2] - lat[0], 64'h2);
    end_sim;
  end
endmodule
